/* File: include/mirror_framer_map.svh */
`ifndef MIRROR_FRAMER_MAP_SVH
`define MIRROR_FRAMER_MAP_SVH
// primary header fields
`define VERSION_NUM      3'h0
`define TYPE_BIT         1'h0
`define SEC_HDR_FLAG     1'h1
`define PROCESS_ID       7'h47
`define CATEGORY         4'h7
`define SEG_FLAGS        2'h3
`define SEQ_RESET        14'h0000
`define LEN_OFFSET       16'h0009
`define SRC_BYTES_FOUR   16'h0002
`define SRC_BYTES_FIVE   16'h0004
// secondary header fields
`define SERVICE_VERSION  3'h2
`define CHECKSUM_PRESENT 1'h0
`define HEADER_SPARE     4'h0
`define SERVICE_TYPE     8'h05
`define SERVICE_SUBTYPE  8'h03
`define HEADER_PAD       8'h00
// source data
`define EVENT_ID_FOUR    16'ha7fc
`define EVENT_ID_FIVE    16'ha7fd
// word positions inside a packet
`define W_SEQ            4'h1
`define W_LEN            4'h2
`define W_SEC_HI         4'h3
`define W_SEC_LO         4'h4
`define W_FRAC           4'h5
`define W_SVC            4'h6
`define W_TYPE           4'h7
`define W_EID            4'h8
`define W_POS            4'h9
`define WORD_BITS        5'h10
`define FIFO_DEPTH       16
`endif

/* File: include/mirror_framer_pkg.sv */
package mirror_framer_pkg;
    // one packet word, sent msb first
    typedef logic [15:0] word_t;
    // builder states
    typedef enum logic [1:0] {
        B_IDLE = 2'b01,
        B_SEND = 2'b10
    } build_state_e;
endpackage : mirror_framer_pkg

/* File: hdl/framer_fifo.sv */
`timescale 1ns/1ps
`default_nettype none
module framer_fifo #(
    parameter int WIDTH = 17,
    parameter int DEPTH = 16,
    parameter int AW    = $clog2(DEPTH)
) (
    input  wire logic             mclk,
    input  wire logic             rst_n,
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic [WIDTH-1:0]      out_data
);
    logic [WIDTH-1:0] mem_q [DEPTH]; // storage, no reset needed
    logic [AW:0]      wr_q;          // write pointer, wrap bit on top
    logic [AW:0]      wr_d;
    logic [AW:0]      rd_q;          // read pointer, wrap bit on top
    logic [AW:0]      rd_d;
    logic             push;
    logic             pop;
    // one pointer step, sized to the pointer so nothing is padded
    localparam logic [AW:0] PTR_STEP = {{AW{1'b0}}, 1'b1};

    // full when pointers differ only in the wrap bit
    always_comb begin
        in_ready  = !((wr_q[AW] != rd_q[AW]) && (wr_q[AW-1:0] == rd_q[AW-1:0]));
        out_valid = (wr_q != rd_q);
        out_data  = mem_q[rd_q[AW-1:0]];
        push      = in_valid && in_ready;
        pop       = out_valid && out_ready;
        wr_d      = push ? wr_q + PTR_STEP : wr_q;
        rd_d      = pop ? rd_q + PTR_STEP : rd_q;
    end

    // pointers
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            wr_q <= '0;
            rd_q <= '0;
        end else begin
            wr_q <= wr_d;
            rd_q <= rd_d;
        end
    end

    // storage write
    always_ff @(posedge mclk) begin
        if (push) begin
            mem_q[wr_q[AW-1:0]] <= in_data;
        end
    end
endmodule : framer_fifo
`default_nettype wire

/* File: hdl/mirror_error_event_packet_framer.sv */
`timescale 1ns/1ps
`default_nettype none
`include "mirror_framer_map.svh"
module mirror_error_event_packet_framer (
    input  wire logic                   mclk,
    input  wire logic                   rst_n,
    input  wire logic                   four_req,
    input  wire logic                   five_req,
    input  wire mirror_framer_pkg::word_t failed_position_code,
    input  wire logic [31:0]            time_sec,
    input  wire mirror_framer_pkg::word_t time_frac,
    input  wire logic                   tx_ready,
    output logic                        tx_bit,
    output logic                        tx_valid,
    output logic                        tx_last,
    output logic                        busy,
    output logic                        refused,
    output logic [13:0]                 sequence_count_field
);
    import mirror_framer_pkg::*;

    // builder state
    build_state_e state_q;
    build_state_e state_d;
    logic [3:0]   idx_q;        // word being written
    logic [3:0]   idx_d;
    logic         four_q;       // 1: type 4, 0: type 5
    logic         four_d;
    logic [13:0]  seq_q;        // count for process 71 / category 7
    logic [13:0]  seq_d;
    logic [31:0]  sec_q;        // captured at acceptance
    logic [31:0]  sec_d;
    word_t        frac_q;
    word_t        frac_d;
    word_t        pos_q;        // failed position, type 5 only
    word_t        pos_d;
    logic         busy_q;
    logic         busy_d;
    logic         refused_q;    // one-cycle pulse
    logic         refused_d;
    // fifo write side
    word_t        wr_word;
    logic         wr_last;
    logic         wr_valid;
    logic         wr_ready;
    logic         wr_fire;
    logic [3:0]   last_idx;
    // fifo read side
    logic [16:0]  rd_data;
    logic         rd_valid;
    logic         rd_ready;
    // serializer state
    word_t        shreg_q;
    word_t        shreg_d;
    logic [4:0]   cnt_q;        // bits left incl. current
    logic [4:0]   cnt_d;
    logic         lastw_q;      // current word ends a packet
    logic         lastw_d;
    logic         valid_q;
    logic         valid_d;
    logic         tlast_q;
    logic         tlast_d;

    // pick the packet word for the current index
    always_comb begin
        last_idx = four_q ? `W_EID : `W_POS;
        wr_word  = '0;
        case (idx_q)
            4'h0: wr_word = {`VERSION_NUM, `TYPE_BIT, `SEC_HDR_FLAG,
                             `PROCESS_ID, `CATEGORY};
            `W_SEQ: wr_word = {`SEG_FLAGS, seq_q};
            `W_LEN: wr_word = (four_q ? `SRC_BYTES_FOUR : `SRC_BYTES_FIVE)
                              + `LEN_OFFSET;
            `W_SEC_HI: wr_word = sec_q[31:16];
            `W_SEC_LO: wr_word = sec_q[15:0];
            `W_FRAC:   wr_word = frac_q;
            `W_SVC: wr_word = {`SERVICE_VERSION, `CHECKSUM_PRESENT,
                               `HEADER_SPARE, `SERVICE_TYPE};
            `W_TYPE: wr_word = {`SERVICE_SUBTYPE, `HEADER_PAD};
            `W_EID: wr_word = four_q ? `EVENT_ID_FOUR : `EVENT_ID_FIVE;
            `W_POS: wr_word = pos_q;
            default: wr_word = '0;
        endcase
        wr_last  = (idx_q == last_idx);
        // no pause of its own: only a full buffer holds the builder back
        wr_valid = (state_q == B_SEND);
        wr_fire  = wr_valid && wr_ready;
    end

    // builder next state; a request while busy is refused
    always_comb begin
        state_d   = state_q;
        idx_d     = idx_q;
        four_d    = four_q;
        seq_d     = seq_q;
        sec_d     = sec_q;
        frac_d    = frac_q;
        pos_d     = pos_q;
        refused_d = 1'b0;
        case (state_q)
            B_IDLE: begin
                // type 4 wins when both arrive together
                if (four_req || five_req) begin
                    // inputs latched here, so later changes cannot tear a packet
                    state_d   = B_SEND;
                    idx_d     = '0;
                    four_d    = four_req;
                    sec_d     = time_sec;
                    frac_d    = time_frac;
                    pos_d     = failed_position_code;
                    refused_d = four_req && five_req;
                end
            end
            B_SEND: begin
                // dropped, not queued: the source must ask again once idle
                refused_d = four_req || five_req;
                if (wr_fire) begin
                    idx_d = idx_q + 4'h1;
                    if (wr_last) begin
                        state_d = B_IDLE;
                        seq_d   = seq_q + 14'h0001;
                    end
                end
            end
            default: state_d = B_IDLE;
        endcase
        busy_d = (state_d == B_SEND);
    end

    // builder registers
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            state_q   <= B_IDLE;
            idx_q     <= '0;
            four_q    <= 1'b0;
            seq_q     <= `SEQ_RESET;
            sec_q     <= '0;
            frac_q    <= '0;
            pos_q     <= '0;
            busy_q    <= 1'b0;
            refused_q <= 1'b0;
        end else begin
            state_q   <= state_d;
            idx_q     <= idx_d;
            four_q    <= four_d;
            seq_q     <= seq_d;
            sec_q     <= sec_d;
            frac_q    <= frac_d;
            pos_q     <= pos_d;
            busy_q    <= busy_d;
            refused_q <= refused_d;
        end
    end

    // one whole packet fits, so the builder rarely stalls
    // a second packet only partly fits, so the builder stalls while the sink is slow
    framer_fifo #(
        .WIDTH (17),
        .DEPTH (`FIFO_DEPTH),
        .AW    (4)
    ) u_fifo (
        .mclk      (mclk),
        .rst_n     (rst_n),
        .in_valid  (wr_valid),
        .in_ready  (wr_ready),
        .in_data   ({wr_last, wr_word}),
        .out_valid (rd_valid),
        .out_ready (rd_ready),
        .out_data  (rd_data)
    );

    // serializer: shift words out msb first, no idle between words
    always_comb begin
        shreg_d  = shreg_q;
        cnt_d    = cnt_q;
        lastw_d  = lastw_q;
        valid_d  = valid_q;
        rd_ready = 1'b0;
        if (valid_q && tx_ready && cnt_q > 5'h01) begin
            shreg_d = {shreg_q[14:0], 1'b0};
            cnt_d   = cnt_q - 5'h01;
        end else if (!valid_q || tx_ready) begin
            // refill as the last bit leaves, so words run back to back
            rd_ready = 1'b1;
            valid_d  = rd_valid;
            if (rd_valid) begin
                shreg_d = rd_data[15:0];
                lastw_d = rd_data[16];
                cnt_d   = `WORD_BITS;
            end
        end
        // end marker rides with the final bit of the last word
        tlast_d = valid_d && lastw_d && (cnt_d == 5'h01);
    end

    // serializer registers
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            shreg_q <= '0;
            cnt_q   <= '0;
            lastw_q <= 1'b0;
            valid_q <= 1'b0;
            tlast_q <= 1'b0;
        end else begin
            shreg_q <= shreg_d;
            cnt_q   <= cnt_d;
            lastw_q <= lastw_d;
            valid_q <= valid_d;
            tlast_q <= tlast_d;
        end
    end

    // every output is a straight register copy
    assign tx_bit               = shreg_q[15];
    assign tx_valid             = valid_q;
    assign tx_last              = tlast_q;
    assign busy                 = busy_q;
    assign refused              = refused_q;
    assign sequence_count_field = seq_q;

    // checks
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);

    sequence word_at(logic [3:0] i);
        wr_fire && idx_q == i;
    endsequence

    hdr_word_a: assert property (word_at(4'h0) |-> wr_word == 16'h0c77)
        else $error("primary header word wrong");
    seq_step_a: assert property (wr_fire && wr_last |=> seq_q == $past(seq_q) + 14'h0001)
        else $error("sequence count did not step");
    seq_wrap_a: assert property (wr_fire && wr_last && seq_q == 14'h3fff |=> seq_q == 14'h0)
        else $error("sequence count did not wrap");
    len_five_a: assert property (word_at(`W_LEN) && !four_q |-> wr_word == 16'h000d)
        else $error("type 5 length wrong");
    len_four_a: assert property (word_at(`W_LEN) && four_q |-> wr_word == 16'h000b)
        else $error("type 4 length wrong");
    time_order_a: assert property (word_at(`W_SEC_HI) ##[1:40] word_at(`W_FRAC)
        |-> wr_word == frac_q && $stable(sec_q))
        else $error("time stamp order wrong");
    svc_hdr_a: assert property (word_at(`W_SVC) |-> wr_word == 16'h4005)
        else $error("service header word wrong");
    subtype_pad_a: assert property (word_at(`W_TYPE) |-> wr_word == 16'h0300)
        else $error("subtype or pad wrong");
    eid_four_a: assert property (word_at(`W_EID) && four_q |-> wr_word == 16'ha7fc && wr_last)
        else $error("type 4 event id wrong");
    four_pick_a: assert property (state_q == B_IDLE && four_req |=> four_q && busy)
        else $error("type 4 request not taken");
    five_len_a: assert property (word_at(`W_EID) && !four_q |-> wr_word == 16'ha7fd && !wr_last)
        else $error("type 5 source too short");
    five_pos_a: assert property (word_at(`W_POS) |-> !four_q && wr_word == pos_q && wr_last)
        else $error("failed position word wrong");
    sequence load_word;
        rd_valid && rd_ready;
    endsequence
    msb_first_a: assert property (load_word ##1 tx_valid |-> tx_bit == $past(rd_data[15]))
        else $error("word not sent msb first");

    // request capture and counter stepping
    sequence take_req;
        state_q == B_IDLE && (four_req || five_req);
    endsequence
    time_capture_a: assert property (
        take_req |=> sec_q == $past(time_sec) && frac_q == $past(time_frac))
        else $error("time stamp not captured at request");
    pos_capture_a: assert property (
        take_req |=> pos_q == $past(failed_position_code))
        else $error("failed position not captured at request");
    seq_hold_a: assert property (!(wr_fire && wr_last) |=> $stable(seq_q))
        else $error("sequence count moved without a packet");
    five_pick_a: assert property (
        state_q == B_IDLE && five_req && !four_req |=> !four_q && busy)
        else $error("type 5 request not taken");
    both_pick_a: assert property (
        state_q == B_IDLE && four_req && five_req |=> four_q && refused)
        else $error("simultaneous requests not resolved to type 4");

    // serial stream: no gap inside a word or between queued words, end marker; refusal while busy
    gapless_a: assert property (
        tx_valid && (cnt_q > 5'h01 || rd_valid) |=> tx_valid)
        else $error("gap in the serial stream");
    last_bit_a: assert property (tx_last |-> tx_valid && cnt_q == 5'h01 && lastw_q)
        else $error("end marker not on the final bit");
    refuse_busy_a: assert property (
        state_q == B_SEND && (four_req || five_req) |=> refused)
        else $error("request while busy not flagged");
endmodule : mirror_error_event_packet_framer
`default_nettype wire

/* File: test/telemetry_sink.sv */
`timescale 1ns/1ps
`default_nettype none
module telemetry_sink (
    input  wire logic       mclk,
    input  wire logic       rst_n,
    input  wire logic       tx_bit,
    input  wire logic       tx_valid,
    input  wire logic       tx_last,
    input  wire logic [1:0] stall_mode,
    output logic            tx_ready
);
    logic [15:0] shift_q;    // bits gathered msb first
    int          nbits;      // bits taken in the current packet
    logic        phase_q;    // toggles for the half-rate pattern
    logic [15:0] words[$];   // finished words in arrival order
    int          last_at[$]; // bit count at which the end marker came
    // mode 0 always ready, 1 every other cycle, 2 stopped so the buffer fills
    always @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            tx_ready <= 1'b0;
            phase_q  <= 1'b0;
            nbits = 0;
        end else begin
            // a bit counts only where valid and ready meet at this edge
            if (tx_valid === 1'b1 && tx_ready === 1'b1) begin
                shift_q = {shift_q[14:0], tx_bit};
                nbits   = nbits + 1;
                if (nbits % 16 == 0) begin
                    words.push_back(shift_q);
                end
                if (tx_last === 1'b1) begin
                    last_at.push_back(nbits);
                    nbits = 0;
                end
            end
            phase_q  <= ~phase_q;
            tx_ready <= (stall_mode == 2'd0) || (stall_mode == 2'd1 && phase_q);
        end
    end
endmodule : telemetry_sink
`default_nettype wire

/* File: test/testbench.sv */
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import mirror_framer_pkg::*;
    logic        mclk = 1'b0;   // 40 MHz
    logic        rst_n = 1'b0;  // held low at start
    logic        four_req = 1'b0;
    logic        five_req = 1'b0;
    word_t       pos = 16'h0001;
    logic [31:0] sec = 32'h0011_64b3;
    word_t       frac = 16'hdd6e;
    logic        tx_ready, tx_bit, tx_valid, tx_last, busy, refused;
    logic [13:0] seq_cnt;       // next count reported by the framer
    logic [1:0]  stall_mode = 2'd0;
    int          err_count = 0;
    int          checks_done = 0;
    int          rd = 0;        // next unread word of the sink
    int          pk = 0;        // next unread packet of the sink
    int          ref_seen = 0;  // refused pulses seen so far
    logic [13:0] exp_seq = 14'h0000;
    always #12.5 mclk = ~mclk;
    mirror_error_event_packet_framer mirror_error_event_packet_framer_inst (
        .mclk(mclk), .rst_n(rst_n), .four_req(four_req), .five_req(five_req),
        .failed_position_code(pos), .time_sec(sec), .time_frac(frac),
        .tx_ready(tx_ready), .tx_bit(tx_bit), .tx_valid(tx_valid), .tx_last(tx_last),
        .busy(busy), .refused(refused), .sequence_count_field(seq_cnt));
    telemetry_sink telemetry_sink_inst (
        .mclk(mclk), .rst_n(rst_n), .tx_bit(tx_bit), .tx_valid(tx_valid),
        .tx_last(tx_last), .stall_mode(stall_mode), .tx_ready(tx_ready));
    // count every refusal pulse; scenarios compare the increase
    always @(posedge mclk) begin
        if (refused === 1'b1) ref_seen++;
    end
    task automatic finish_test();
        $display("mismatches %0d comparisons %0d", err_count, checks_done);
        if (err_count == 0 && checks_done > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask : finish_test
    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            err_count++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : cmp
    // one-cycle request pulse, driven just after an edge
    task automatic request(input logic f4, input logic f5);
        @(posedge mclk);
        four_req <= f4;
        five_req <= f5;
        @(posedge mclk);
        four_req <= 1'b0;
        five_req <= 1'b0;
    endtask : request
    task automatic wait_idle();
        int n;
        // busy rises on the same edge that takes the request, so step one edge before testing it
        @(posedge mclk);
        for (n = 0; n < 400 && busy !== 1'b0; n++) @(posedge mclk);
        if (busy !== 1'b0) begin
            err_count++;
            finish_test();
        end
    endtask : wait_idle
    // expected words built from the fixed header layout, not from the design
    task automatic expect_packet(input logic five, input word_t p, input logic [31:0] s,
                                 input word_t f);
        word_t exp[10];
        int    n;
        int    i;
        n = five ? 10 : 9;
        exp = '{16'h0c77, {2'b11, exp_seq}, five ? 16'h000d : 16'h000b, s[31:16], s[15:0],
                f, 16'h4005, 16'h0300, five ? 16'ha7fd : 16'ha7fc, p};
        for (i = 0; i < 3000 && telemetry_sink_inst.last_at.size() <= pk; i++) @(posedge mclk);
        if (telemetry_sink_inst.last_at.size() <= pk) begin
            err_count++;
            finish_test();
        end
        // header, length, time, service words and source data, msb first, in order
        for (i = 0; i < n; i++) cmp(telemetry_sink_inst.words[rd+i], exp[i]);
        cmp(telemetry_sink_inst.last_at[pk], 16 * n);
        rd += n;
        pk++;
        exp_seq = exp_seq + 14'h0001;
    endtask : expect_packet
    initial begin
        int k;
        int r0;
        repeat (20) @(posedge mclk);
        rst_n <= 1'b1;
        @(posedge mclk);
        cmp(seq_cnt, 14'h0000);
        // type 4 with a half-rate sink
        stall_mode <= 2'd1;
        request(1'b1, 1'b0);
        wait_idle();
        expect_packet(1'b0, pos, sec, frac);
        cmp(seq_cnt, exp_seq);
        // type 5 with failed position codes 1 to 3
        stall_mode <= 2'd0;
        for (k = 1; k <= 3; k++) begin
            pos <= k[15:0];
            sec <= sec + 32'h0000_0101;
            request(1'b0, 1'b1);
            wait_idle();
            expect_packet(1'b1, k[15:0], sec, frac);
            cmp(seq_cnt, exp_seq);
        end
        // both at once: type 4 built, type 5 refused
        r0 = ref_seen;
        request(1'b1, 1'b1);
        wait_idle();
        expect_packet(1'b0, pos, sec, frac);
        cmp(ref_seen - r0, 1);
        // a request while busy is dropped
        r0 = ref_seen;
        request(1'b1, 1'b0);
        @(posedge mclk);
        request(1'b0, 1'b1);
        wait_idle();
        expect_packet(1'b0, pos, sec, frac);
        cmp(ref_seen - r0, 1);
        cmp(telemetry_sink_inst.words.size(), rd);
        // stopped sink: the second packet cannot fit, so the builder must wait
        stall_mode <= 2'd2;
        request(1'b0, 1'b1);
        wait_idle();
        sec <= 32'h8000_0001;
        frac <= 16'h0123;
        request(1'b0, 1'b1);
        repeat (40) @(posedge mclk);
        cmp(busy, 1'b1);
        stall_mode <= 2'd0;
        wait_idle();
        expect_packet(1'b1, pos, 32'h0011_64b3 + 32'h0000_0303, 16'hdd6e);
        expect_packet(1'b1, pos, 32'h8000_0001, 16'h0123);
        cmp(seq_cnt, exp_seq);
        finish_test();
    end
endmodule : testbench
`default_nettype wire
